// *** rtl/pcf_fanout.sv ***
`timescale 1ns/100ps
module pcf_fanout
  import pcf_pkg::*;
#(
  parameter logic [1:0] VARIANT = PCF_VAR_SLEEP_ALL
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Reference selection
  input wire logic ext_ref_sel,
  input wire logic crystal_input,
  // Power management enables
  input wire logic sleep_enable_in,
  input wire logic aux_output_enable_in,
  // Clock outputs and oscillator status
  output logic [PCF_NUM_MAIN-1:0] main_clock_out,
  output logic aux_clock_out,
  output logic osc_running
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic osc_r, osc_nxt;
  logic [PCF_CNT_W-1:0] cnt_r, cnt_nxt;
  logic ext_r, ext_nxt;
  logic ref_d_r, ref_d_nxt;
  pcf_en_t lvl_r [PCF_SYNC_DEPTH];
  pcf_en_t lvl_nxt [PCF_SYNC_DEPTH];
  pcf_en_t sync_r [PCF_SYNC_DEPTH];
  pcf_en_t sync_nxt [PCF_SYNC_DEPTH];
  logic [PCF_NUM_MAIN-1:0] main_r, main_nxt;
  logic aux_r, aux_nxt;
  logic run_r, run_nxt;
  logic ref_now;
  logic ref_fall;
  logic gate_main;
  logic gate_aux;
  logic osc_req;
  pcf_en_t en_in;

  assign en_in = '{sleep: sleep_enable_in, aux: aux_output_enable_in};

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  // One shared reference
  assign ref_now = ext_ref_sel ? ext_r : osc_r;
  assign ref_fall = ref_d_r & ~ref_now;

  // ----------------------------------------------------------------
  // Enable synchronisers
  // ----------------------------------------------------------------
  // Level path on the system clock keeps wake working with osc stopped
  // Two flops per enable in each of the two paths
  genvar g;
  generate
    for (g = 0; g < PCF_SYNC_DEPTH; g++) begin : g_sync
      pcf_en_t lvl_src;
      pcf_en_t sync_src;
      // First stage takes the pins, later ones the stage before
      if (g == 0) begin : g_first
        assign lvl_src = en_in;
        assign sync_src = en_in;
      end else begin : g_next
        assign lvl_src = lvl_r[g-1];
        assign sync_src = sync_r[g-1];
      end
      always_comb begin
        lvl_nxt[g] = lvl_src;
        sync_nxt[g] = sync_r[g];
        // Advance only at a reference fall
        if (ref_fall) begin
          sync_nxt[g] = sync_src;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          lvl_r[g] <= PCF_EN_RST;
          sync_r[g] <= PCF_EN_RST;
        end else if (ce) begin
          lvl_r[g] <= lvl_nxt[g];
          sync_r[g] <= sync_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Gating per variant
  // ----------------------------------------------------------------
  always_comb begin
    gate_main = sync_r[PCF_SYNC_DEPTH-1].sleep;
    gate_aux = sync_r[PCF_SYNC_DEPTH-1].aux;
    osc_req = 1'b1;
    case (VARIANT)
      PCF_VAR_SLEEP_ALL: begin
        gate_aux = sync_r[PCF_SYNC_DEPTH-1].aux & gate_main;
        osc_req = lvl_r[PCF_SYNC_DEPTH-1].sleep;
      end
      PCF_VAR_SLEEP_AUX: begin
        osc_req = lvl_r[PCF_SYNC_DEPTH-1].sleep |
                  lvl_r[PCF_SYNC_DEPTH-1].aux;
      end
      PCF_VAR_OSC_ON: begin
        osc_req = 1'b1;
      end
      default: begin
        osc_req = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Oscillator and output stage
  // ----------------------------------------------------------------
  always_comb begin
    osc_nxt = osc_r;
    cnt_nxt = cnt_r;
    run_nxt = osc_req | osc_r;
    ext_nxt = crystal_input;
    ref_d_nxt = ref_now;
    // Stop only parked low so the last pulse stays full width
    if (!osc_req && !osc_r) begin
      cnt_nxt = PCF_CNT_ZERO;
    end else if (cnt_r >= PCF_OSC_HALF_CYC - PCF_CNT_ONE) begin
      cnt_nxt = PCF_CNT_ZERO;
      osc_nxt = ~osc_r;
    end else begin
      cnt_nxt = cnt_r + PCF_CNT_ONE;
    end
    // AND with a gate that moved in the low phase
    main_nxt = {PCF_NUM_MAIN{ref_now & gate_main}};
    aux_nxt = ref_now & gate_aux;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_r <= 1'b0;
      cnt_r <= PCF_CNT_ZERO;
      run_r <= 1'b0;
      ext_r <= 1'b0;
      ref_d_r <= 1'b0;
      main_r <= '0;
      aux_r <= 1'b0;
    end else if (ce) begin
      osc_r <= osc_nxt;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      ext_r <= ext_nxt;
      ref_d_r <= ref_d_nxt;
      main_r <= main_nxt;
      aux_r <= aux_nxt;
    end
  end

  assign main_clock_out = main_r;
  assign aux_clock_out = aux_r;
  assign osc_running = run_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SLEEP_ALL_LOW: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && VARIANT == PCF_VAR_SLEEP_ALL && !gate_main)
      |=> (main_r == '0 && !aux_r))
    else $error("outputs not low in sleep");

  AST_AUX_ONLY_LOW: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && !gate_aux && gate_main && ref_now) |=> (!aux_r && main_r[0]))
    else $error("aux gating touched main outputs");

  AST_GATE_IN_LOW: assert property (
    @(posedge clk_sys) disable iff (rst)
    (sync_r[PCF_SYNC_DEPTH-1] != $past(sync_r[PCF_SYNC_DEPTH-1]))
      |-> !ref_d_r)
    else $error("gate moved while reference high");

  AST_FULL_PULSE: assert property (
    @(posedge clk_sys) disable iff (rst)
    ($rose(aux_r) || $fell(aux_r) || $rose(main_r[0]) || $fell(main_r[0]))
      |-> (ref_d_r != $past(ref_d_r)))
    else $error("output edge without reference edge");

  AST_ENABLED_TOGGLE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && ref_now && gate_main) |=> (main_r == '1))
    else $error("enabled output failed to rise");

  AST_OSC_TWO_LOW: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && VARIANT == PCF_VAR_SLEEP_AUX &&
     (lvl_r[PCF_SYNC_DEPTH-1].sleep || lvl_r[PCF_SYNC_DEPTH-1].aux))
      |=> (cnt_r != $past(cnt_r) || osc_r != $past(osc_r)))
    else $error("oscillator stopped with an enable high");

  AST_OSC_TWO_STOP: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && VARIANT == PCF_VAR_SLEEP_AUX && !osc_r &&
     !lvl_r[PCF_SYNC_DEPTH-1].sleep && !lvl_r[PCF_SYNC_DEPTH-1].aux)
      |=> (!osc_r && cnt_r == PCF_CNT_ZERO))
    else $error("oscillator kept running with both enables low");

  AST_OSC_ALWAYS: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && VARIANT == PCF_VAR_OSC_ON) |=> run_r)
    else $error("oscillator stopped in always-on variant");

  AST_ONE_REF: assert property (
    @(posedge clk_sys) disable iff (rst)
    (aux_r || main_r != '0) |-> ref_d_r)
    else $error("output high without reference");

  AST_TWO_STAGE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && ref_fall) |=> (sync_r[1] == $past(sync_r[0])))
    else $error("synchroniser stage skipped");

endmodule

// *** rtl/pcf_pkg.sv ***
// Notes on behaviour
// - Both enables are active high: high lets outputs toggle, low holds them low.
// - Variant one: a low sleep enable forces all six outputs low and stops the oscillator.
// - Variant one: a low auxiliary enable holds only output 5 low, outputs 0 to 4 unaffected.
// - Each enable is synchronised so that gating changes only while the output is low.
// - No output ever shows a shortened high or low pulse when an enable changes.
// - With the sleep enable high outputs 0 to 4 toggle, the oscillator runs, output 5 follows the auxiliary enable.
// - Variant two: sleep low holds outputs 0 to 4 low, output 5 follows the auxiliary enable, oscillator stops only when both are low.
// - Variant three: the oscillator always runs, sleep low holds outputs 0 to 4 low, output 5 follows the auxiliary enable.
// - All six outputs come from one reference, the oscillator or an external clock at the crystal input.
package pcf_pkg;

  // ----------------------------------------------------------------
  // Variants
  // ----------------------------------------------------------------
  localparam logic [1:0] PCF_VAR_SLEEP_ALL = 2'h1;
  localparam logic [1:0] PCF_VAR_SLEEP_AUX = 2'h2;
  localparam logic [1:0] PCF_VAR_OSC_ON = 2'h3;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int PCF_NUM_MAIN = 5;
  localparam int PCF_SYNC_DEPTH = 2;
  localparam int PCF_CLK_PERIOD_NS = 10;
  // Half period of the internal oscillator, default arbitrary
  localparam int PCF_OSC_HALF_NS = 20;
  localparam int PCF_OSC_HALF_CYC_I =
    (PCF_OSC_HALF_NS / PCF_CLK_PERIOD_NS) < 1 ? 1 :
    (PCF_OSC_HALF_NS / PCF_CLK_PERIOD_NS);
  localparam int PCF_CNT_W = 8;
  localparam logic [PCF_CNT_W-1:0] PCF_OSC_HALF_CYC =
    PCF_CNT_W'(PCF_OSC_HALF_CYC_I);
  localparam logic [PCF_CNT_W-1:0] PCF_CNT_ZERO = 8'h00;
  localparam logic [PCF_CNT_W-1:0] PCF_CNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Carrier for the two enables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sleep;
    logic aux;
  } pcf_en_t;

  localparam pcf_en_t PCF_EN_RST = 2'h0;

endpackage

// *** verif/pcf_ref_model.sv ***
`timescale 1ns/100ps
module pcf_ref_model
  import pcf_pkg::*;
#(
  parameter int HALF = PCF_OSC_HALF_CYC_I
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic run,
  // Reference out
  output logic crystal_input
);
  int cnt;
  initial begin
    crystal_input = 1'b0;
    cnt = 0;
  end
  // external clock source
  // Parked low when idle so the gates never see a stale level
  always @(negedge clk_sys) begin
    if (!run) begin
      crystal_input <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      crystal_input <= ~crystal_input;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import pcf_pkg::*;
  localparam int HALF = PCF_OSC_HALF_CYC_I;
  logic clk_sys, rst, ce, ext_ref_sel, sleep_en, aux_en, ref_run;
  logic crystal_input;
  logic [PCF_NUM_MAIN-1:0] main_o [3];
  logic aux_o [3];
  logic osc_o [3];
  logic [5:0] mon;
  int hi [6];
  int lo [6];
  int n_fail, n_checks;
  // ------------------------------------------------------------
  // Instances, one per variant
  // ------------------------------------------------------------
  pcf_ref_model u_ref (.clk_sys(clk_sys), .run(ref_run),
    .crystal_input(crystal_input));
  for (genvar g = 0; g < 3; g++) begin : g_var
    pcf_fanout #(.VARIANT(2'(g + 1))) u_dut (.clk_sys(clk_sys),
      .rst(rst), .ce(ce), .ext_ref_sel(ext_ref_sel),
      .crystal_input(crystal_input), .sleep_enable_in(sleep_en),
      .aux_output_enable_in(aux_en), .main_clock_out(main_o[g]),
      .aux_clock_out(aux_o[g]), .osc_running(osc_o[g]));
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Pulse width monitor
  // ------------------------------------------------------------
  assign mon = {aux_o[2], aux_o[1], aux_o[0],
    main_o[2][0], main_o[1][0], main_o[0][0]};
  always @(negedge clk_sys) begin
    if (!rst && ce) begin
      for (int k = 0; k < 6; k++) begin
        if (mon[k] === 1'b1) begin
          if (lo[k] > 0 && lo[k] < HALF) check(8'(lo[k]), 8'(HALF));
          lo[k] = 0;
          hi[k]++;
        end else begin
          if (hi[k] > 0) check(8'(hi[k]), 8'(HALF));
          hi[k] = 0;
          lo[k]++;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_combo(input logic s, input logic a);
    logic [7:0] rm [3];
    logic [7:0] ra [3];
    logic [4:0] pm [3];
    logic pa [3];
    logic [7:0] ea, eo;
    @(negedge clk_sys);
    sleep_en = s;
    aux_en = a;
    repeat (24) @(negedge clk_sys);
    for (int g = 0; g < 3; g++) begin
      rm[g] = 8'h00;
      ra[g] = 8'h00;
      pm[g] = main_o[g];
      pa[g] = aux_o[g];
    end
    repeat (16) begin
      @(negedge clk_sys);
      for (int g = 0; g < 3; g++) begin
        if (pm[g] === 5'h00 && main_o[g] === 5'h1f) rm[g]++;
        if (pa[g] === 1'b0 && aux_o[g] === 1'b1) ra[g]++;
        pm[g] = main_o[g];
        pa[g] = aux_o[g];
      end
    end
    for (int g = 0; g < 3; g++) begin
      check(rm[g], s ? 8'h04 : 8'h00);
      ea = (a && (g != 0 || s)) ? 8'h04 : 8'h00;
      check(ra[g], ea);
      eo = {7'h00, g == 2 || s || (g == 1 && a)};
      check({7'h00, osc_o[g]}, eo);
    end
  endtask
  task automatic t_freeze;
    logic [5:0] held;
    @(negedge clk_sys);
    ce = 1'b0;
    held = mon;
    repeat (10) @(negedge clk_sys);
    check({2'h0, mon}, {2'h0, held});
    ce = 1'b1;
  endtask
  initial begin
    #50us;
    n_fail++;
    print_verdict();
  end
  initial begin
    logic [1:0] seq [6];
    seq = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    ext_ref_sel = 1'b0;
    sleep_en = 1'b0;
    aux_en = 1'b0;
    ref_run = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) t_combo(seq[i][1], seq[i][0]);
    t_combo(1'b1, 1'b1);
    t_freeze();
    t_combo(1'b0, 1'b0);
    ext_ref_sel = 1'b1;
    ref_run = 1'b1;
    for (int i = 0; i < 6; i++) t_combo(seq[i][1], seq[i][0]);
    print_verdict();
  end
endmodule
